/* mrs_top.sv */
// Reset and initialisation sequencer of the line modem, with host pin interface.
// Assumes all inputs synchronous to i_mclk; the modem core supplies serial data.
// How it works
// - Power-on reset held low 50..350 ms after power before release.
// - Configuration and request-to-send accepted only 10 ms after reset release.
// - Supply low for more than 30 ms restarts the reset cycle.
// - Every reset loads the fixed default configuration.
// - Ready for configuration 10 ms after external reset removal, or 50 + 10 ms if a power-on or dip settle was pending.
// - Host port: 8-bit data, 4-bit select, chip selects, read, write, irq.
// - Serial outputs: clocks, receive data, line detect; inputs: clock, request, data.
// - Clear-to-send only after request-to-send and completed setup.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_defs.svh"
module mrs_top #(
  parameter int SETTLE_MS  = `MRS_SETTLE_MIN_MS,
  parameter int READY_MS   = `MRS_READY_MS,
  parameter int DIP_MS     = `MRS_DIP_MS,
  parameter int SETTLE_CYC = `MRS_CLK_HZ / 1000 * SETTLE_MS,
  parameter int READY_CYC  = `MRS_CLK_HZ / 1000 * READY_MS,
  parameter int DIP_CYC    = `MRS_CLK_HZ / 1000 * DIP_MS,
  parameter int EXT_CYC    = (`MRS_CLK_HZ / 1000000) * `MRS_EXT_PULSE_US
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_sys_rst,
  input  wire logic                     i_supply_low,
  input  wire logic                     i_ext_reset_n,
  input  wire logic                     i_card_write_n,
  input  wire logic [7:0]               i_data,
  input  wire logic [3:0]               i_reg_select,
  input  wire logic                     i_tx_chip_select_n,
  input  wire logic                     i_rx_sample_chip_select_n,
  input  wire logic                     i_rx_baud_chip_select_n,
  input  wire logic                     i_read_n,
  input  wire logic                     i_write_n,
  input  wire logic                     i_ext_tx_clock,
  input  wire logic                     i_request_to_send,
  input  wire logic                     i_tx_data,
  input  wire logic                     i_core_rx_clock,
  input  wire logic                     i_core_tx_clock,
  input  wire logic                     i_core_rx_data,
  input  wire logic                     i_core_carrier,
  input  wire logic                     i_core_irq,
  input  wire logic [7:0]               i_core_rd_data,
  output logic                          o_card_power_clear_n,
  output logic                          o_ready,
  output mrs_pkg::mrs_cfg_t             o_cfg,
  output mrs_pkg::mrs_bus_out_t         o_bus,
  output mrs_pkg::mrs_serial_out_t      o_serial,
  output logic                          o_core_tx_data,
  output logic                          o_core_wr,
  output logic [3:0]                    o_core_sel,
  output logic [7:0]                    o_core_wr_data
);
  import mrs_pkg::*;

  typedef struct packed {
    mrs_state_t      state;
    logic [31:0]     cnt;
    logic [31:0]     dip_cnt;
    logic [31:0]     ext_cnt;
    logic            ext_seen;
    logic            ext_cause;
    mrs_cfg_t        cfg;
    mrs_serial_out_t ser;
    logic [7:0]      rd_data;
    logic            rd_oe;
    logic            wr;
    logic [3:0]      sel;
    logic [7:0]      wr_data;
    logic            card_wr_d;
    logic            tx_data;
  } mrs_regs_t;

  mrs_regs_t r;
  mrs_regs_t next_r;
  mrs_cfg_t  dflt;
  logic      cs_any;
  logic      restart;
  logic      dip_hit;

  always_comb begin
    dflt = '0;
    dflt.fast_train    = 1'b1;
    dflt.v29_mode      = 1'b1;
    dflt.rate_9600     = 1'b1;
    dflt.carrier_1700  = 1'b1;
    dflt.serial_mode   = 1'b1;
    dflt.train_on_data = 1'b1;
  end

  assign cs_any = ~(i_tx_chip_select_n & i_rx_sample_chip_select_n & i_rx_baud_chip_select_n);

  always_comb begin
    next_r = r;
    restart = 1'b0;
    // Supply dip timer, restarted while supply is good
    if (i_supply_low) begin
      if (r.dip_cnt < 32'(DIP_CYC))
        next_r.dip_cnt = r.dip_cnt + `MRS_ONE32;
    end else begin
      next_r.dip_cnt = '0;
    end
    dip_hit = i_supply_low && (r.dip_cnt >= 32'(DIP_CYC));
    if (dip_hit)
      restart = 1'b1;
    // External low pulse measured; short glitches are ignored
    if (!i_ext_reset_n) begin
      if (r.ext_cnt < 32'(EXT_CYC))
        next_r.ext_cnt = r.ext_cnt + `MRS_ONE32;
      if (r.ext_cnt >= 32'(EXT_CYC) - `MRS_ONE32)
        next_r.ext_seen = 1'b1;
    end else begin
      next_r.ext_cnt  = '0;
      next_r.ext_seen = 1'b0;
    end
    if (r.ext_seen)
      restart = 1'b1;

    case (r.state)
      MRS_SETTLE: begin
        next_r.cfg = dflt;
        if (r.ext_cause) begin
          // External reset skips supply settling; only the ready wait follows
          next_r.state     = MRS_WAIT;
          next_r.cnt       = '0;
          next_r.ext_cause = 1'b0;
        end else if (r.cnt >= 32'(SETTLE_CYC) - `MRS_ONE32) begin
          next_r.state = MRS_WAIT;
          next_r.cnt   = '0;
        end else begin
          next_r.cnt = r.cnt + `MRS_ONE32;
        end
      end
      MRS_WAIT: begin
        if (r.cnt >= 32'(READY_CYC) - `MRS_ONE32) begin
          next_r.state = MRS_READY;
          next_r.cnt   = '0;
        end else begin
          next_r.cnt = r.cnt + `MRS_ONE32;
        end
      end
      MRS_READY: begin
        if (i_request_to_send)
          next_r.state = MRS_CTS;
      end
      MRS_CTS: begin
        if (!i_request_to_send)
          next_r.state = MRS_READY;
      end
      default: begin
        next_r.state = MRS_SETTLE;
        next_r.cnt   = '0;
      end
    endcase

    // Host register port passes through only once ready
    next_r.wr      = 1'b0;
    next_r.rd_oe   = 1'b0;
    next_r.rd_data = `MRS_ZERO8;
    next_r.card_wr_d = i_card_write_n;
    if (r.state == MRS_READY || r.state == MRS_CTS) begin
      if (cs_any && !i_write_n) begin
        next_r.wr      = 1'b1;
        next_r.sel     = i_reg_select;
        next_r.wr_data = i_data;
      end else if (cs_any && !i_read_n) begin
        next_r.rd_oe   = 1'b1;
        next_r.rd_data = i_core_rd_data;
      end
      // Card write pulse falling edge loads the fixed control word
      if (r.card_wr_d && !i_card_write_n) begin
        next_r.cfg.ext_tx_clk_sel  = 1'b1;
        next_r.cfg.short_echo_tone = 1'b1;
        next_r.wr      = 1'b1;
        next_r.sel     = `MRS_REG_SEL_DFLT;
        next_r.wr_data = `MRS_CFG_WORD_DFLT
                         | (8'h01 << `MRS_TX_CLK_EXT_BIT)
                         | (8'h01 << `MRS_ECHO_TONE_BIT);
      end
    end

    // Serial side, clock follows selected transmit source
    next_r.ser.rx_data_clock      = i_core_rx_clock;
    next_r.ser.tx_data_clock      = r.cfg.ext_tx_clk_sel ? i_ext_tx_clock : i_core_tx_clock;
    next_r.ser.rx_data            = i_core_rx_data;
    next_r.ser.line_signal_detect = i_core_carrier;
    next_r.ser.clear_to_send      = (next_r.state == MRS_CTS);
    next_r.tx_data = (r.state == MRS_CTS) ? i_tx_data : 1'b1;

    if (restart) begin
      next_r.state   = MRS_SETTLE;
      next_r.cnt     = '0;
      next_r.cfg     = dflt;
      // A pending full settle after power-on or a dip is kept
      next_r.ext_cause = !dip_hit && (r.ext_cause || (r.state != MRS_SETTLE));
      next_r.ser.clear_to_send = 1'b0;
      next_r.wr      = 1'b0;
      next_r.rd_oe   = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      r          <= '0;
      r.state    <= MRS_SETTLE;
      r.cfg      <= '0;
      r.card_wr_d <= 1'b1;
      r.tx_data  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Defaults must also hold straight out of system reset
  logic cfg_loaded;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      cfg_loaded <= 1'b0;
    else
      cfg_loaded <= 1'b1;
  end

  assign o_card_power_clear_n = (r.state != MRS_SETTLE);
  assign o_ready              = (r.state == MRS_READY) || (r.state == MRS_CTS);
  assign o_cfg                = cfg_loaded ? r.cfg : dflt;
  assign o_bus                = {r.rd_data, r.rd_oe, i_core_irq & r.cfg.irq_enable & o_ready};
  assign o_serial             = r.ser;
  assign o_core_tx_data       = r.tx_data;
  assign o_core_wr            = r.wr;
  assign o_core_sel           = r.sel;
  assign o_core_wr_data       = r.wr_data;
endmodule
`default_nettype wire

/* mrs_defs.svh */
// Timing and default-configuration constants for the modem reset sequencer.
// Assumes inclusion by bare name from the package and design file.
`ifndef MRS_DEFS_SVH
`define MRS_DEFS_SVH

`define MRS_CLK_HZ          10000000
`define MRS_SETTLE_MIN_MS   50
`define MRS_SETTLE_MAX_MS   350
`define MRS_READY_MS        10
`define MRS_DIP_MS          30
`define MRS_EXT_PULSE_US    3
`define MRS_CFG_WORD_DFLT   8'h00
`define MRS_REG_SEL_DFLT    4'h0
`define MRS_TX_CLK_EXT_BIT  0
`define MRS_ECHO_TONE_BIT   1
`define MRS_ZERO8           8'h00
`define MRS_ONE32           32'h00000001

`endif

/* mrs_pkg.sv */
// Types for the modem reset sequencer.
// Assumes mrs_defs.svh is on the include path.
`include "mrs_defs.svh"
package mrs_pkg;
  typedef enum logic [3:0] {
    MRS_SETTLE = 4'h1,
    MRS_WAIT   = 4'h2,
    MRS_READY  = 4'h4,
    MRS_CTS    = 4'h8
  } mrs_state_t;

  // Default configuration applied at every reset
  typedef struct packed {
    logic       fast_train;
    logic       v29_mode;
    logic       rate_9600;
    logic       carrier_1700;
    logic       serial_mode;
    logic       ext_tx_clk_sel;
    logic       short_echo_tone;
    logic       ones_segment;
    logic       equalizers;
    logic       irq_enable;
    logic       train_on_data;
  } mrs_cfg_t;

  typedef struct packed {
    logic [7:0] data_out;
    logic       data_oe;
    logic       irq_oe;
  } mrs_bus_out_t;

  typedef struct packed {
    logic       rx_data_clock;
    logic       tx_data_clock;
    logic       rx_data;
    logic       line_signal_detect;
    logic       clear_to_send;
  } mrs_serial_out_t;
endpackage

/* mrs_asserts.sv */
// Port checker for the modem reset sequencer.
// Assumes it is bound into mrs_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mrs_asserts #(
  parameter int READY_CYC = 10,
  parameter int DIP_CYC   = 8
) (
  input wire logic                 i_mclk,
  input wire logic                 i_sys_rst,
  input wire logic                 i_supply_low,
  input wire logic                 i_card_write_n,
  input wire logic                 i_write_n,
  input wire logic                 i_tx_chip_select_n,
  input wire logic                 i_request_to_send,
  input wire logic                 o_card_power_clear_n,
  input wire logic                 o_ready,
  input wire mrs_pkg::mrs_cfg_t    o_cfg,
  input wire mrs_pkg::mrs_bus_out_t    o_bus,
  input wire mrs_pkg::mrs_serial_out_t o_serial,
  input wire logic                 o_core_wr
);
  import mrs_pkg::*;
  localparam int RDY_LO = READY_CYC - 1;
  localparam int RDY_HI = READY_CYC + 1;
  // Consecutive low-supply cycles seen so far, saturating at the dip limit
  logic [31:0] low_cnt;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      low_cnt <= '0;
    else if (!i_supply_low)
      low_cnt <= '0;
    else if (low_cnt < 32'(DIP_CYC))
      low_cnt <= low_cnt + 32'h00000001;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_ready_wait: assert property ($rose(o_card_power_clear_n) |-> ##[RDY_LO:RDY_HI] o_ready)
    else $error("ready late after reset release");
  a_ready_pc: assert property (o_ready |-> o_card_power_clear_n)
    else $error("ready while reset low");
  a_dip_reset: assert property (i_supply_low && low_cnt >= 32'(DIP_CYC)
    |=> !o_card_power_clear_n)
    else $error("long supply dip kept running");
  a_cfg_dflt: assert property (!o_card_power_clear_n ##1 !o_card_power_clear_n
    |-> o_cfg == 11'h7C1)
    else $error("defaults not loaded");
  a_card_word: assert property (o_ready && $fell(i_card_write_n)
    |-> ##[0:3] (o_cfg.ext_tx_clk_sel && o_cfg.short_echo_tone))
    else $error("card word not loaded");
  a_wr_answer: assert property (o_ready && !i_tx_chip_select_n && !i_write_n |=> o_core_wr)
    else $error("write not passed on");
  a_no_early_wr: assert property (!o_ready |=> !o_core_wr)
    else $error("write passed before ready");
  a_irq_masked: assert property (!o_cfg.irq_enable |-> !o_bus.irq_oe)
    else $error("irq while disabled");
  a_cts_cause: assert property ($rose(o_serial.clear_to_send)
    |-> $past(i_request_to_send) && $past(o_ready))
    else $error("clear to send without cause");
  a_cts_drop: assert property (!i_request_to_send |=> !o_serial.clear_to_send)
    else $error("clear to send held");
  c_ready: cover property ($rose(o_ready));
  c_cts: cover property ($rose(o_serial.clear_to_send));
  c_wr: cover property (o_core_wr);
endmodule
bind mrs_top mrs_asserts #(.READY_CYC(READY_CYC), .DIP_CYC(DIP_CYC)) chk_u (.i_mclk(i_mclk),
  .i_sys_rst(i_sys_rst),
  .i_supply_low(i_supply_low), .i_card_write_n(i_card_write_n), .i_write_n(i_write_n),
  .i_tx_chip_select_n(i_tx_chip_select_n), .i_request_to_send(i_request_to_send),
  .o_card_power_clear_n(o_card_power_clear_n), .o_ready(o_ready), .o_cfg(o_cfg),
  .o_bus(o_bus), .o_serial(o_serial), .o_core_wr(o_core_wr));
`default_nettype wire

/* mrs_host_model.sv */
// Host side model: raises request-to-send and sends data on clear-to-send.
// Assumes the bench sets i_go when it wants to transmit.
`timescale 1ns/1ps
`default_nettype none
module mrs_host_model (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_go,
  input  wire logic i_ready,
  input  wire logic i_cts,
  output wire logic o_rts,
  output wire logic o_tx_data
);
  logic rts_q = 1'b0;
  logic txd_q = 1'b1;
  assign o_rts = rts_q;
  assign o_tx_data = txd_q;
  always @(posedge i_mclk) begin
    rts_q <= i_go && i_ready && !i_rst;
    txd_q <= !i_cts;
  end
endmodule
`default_nettype wire

/* mrs_top_bench.sv */
// Bench for the modem reset sequencer with short interval counts.
// Assumes mrs_host_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module mrs_top_bench;
  import mrs_pkg::*;
  logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_supply_low = 1'b0, i_ext_reset_n = 1'b1;
  logic i_card_write_n = 1'b1, i_tx_chip_select_n = 1'b1, i_rx_sample_chip_select_n = 1'b1;
  logic i_read_n = 1'b1, i_write_n = 1'b1, i_ext_tx_clock = 1'b0, i_core_rx_data = 1'b0;
  logic i_core_carrier = 1'b0, i_core_irq = 1'b0, go = 1'b0;
  logic i_rx_baud_chip_select_n = 1'b1, i_core_rx_clock = 1'b0, i_core_tx_clock = 1'b0;
  logic [7:0] i_data = 8'h00, i_core_rd_data = 8'h00;
  logic [3:0] i_reg_select = 4'h0;
  wire logic  i_request_to_send, i_tx_data;
  logic       o_card_power_clear_n, o_ready, o_core_tx_data, o_core_wr;
  logic [3:0] o_core_sel;
  logic [7:0] o_core_wr_data;
  mrs_cfg_t o_cfg;
  mrs_bus_out_t o_bus;
  mrs_serial_out_t o_serial;
  int errors = 0, num_checks = 0, n;
  always #50 i_mclk = ~i_mclk;
  mrs_top #(.SETTLE_CYC(20), .READY_CYC(10), .DIP_CYC(8)) dut_u (.i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst), .i_supply_low(i_supply_low), .i_ext_reset_n(i_ext_reset_n),
    .i_card_write_n(i_card_write_n), .i_data(i_data), .i_reg_select(i_reg_select),
    .i_tx_chip_select_n(i_tx_chip_select_n), .i_rx_sample_chip_select_n(i_rx_sample_chip_select_n),
    .i_rx_baud_chip_select_n(i_rx_baud_chip_select_n),
    .i_read_n(i_read_n), .i_write_n(i_write_n),
    .i_ext_tx_clock(i_ext_tx_clock), .i_request_to_send(i_request_to_send),
    .i_tx_data(i_tx_data), .i_core_rx_clock(i_core_rx_clock), .i_core_tx_clock(i_core_tx_clock),
    .i_core_rx_data(i_core_rx_data), .i_core_carrier(i_core_carrier), .i_core_irq(i_core_irq),
    .i_core_rd_data(i_core_rd_data), .o_card_power_clear_n(o_card_power_clear_n),
    .o_ready(o_ready), .o_cfg(o_cfg), .o_bus(o_bus), .o_serial(o_serial),
    .o_core_tx_data(o_core_tx_data), .o_core_wr(o_core_wr), .o_core_sel(o_core_sel),
    .o_core_wr_data(o_core_wr_data));
  mrs_host_model host_u (.i_mclk(i_mclk), .i_rst(i_sys_rst), .i_go(go), .i_ready(o_ready),
    .i_cts(o_serial.clear_to_send), .o_rts(i_request_to_send), .o_tx_data(i_tx_data));
  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(negedge i_mclk);
  endtask
  // Counts cycles until power clear (0) or ready (1) is high
  task automatic wait_for(input int which, output int cyc);
    cyc = 0;
    while ((which == 0 ? o_card_power_clear_n : o_ready) !== 1'b1) begin
      tick(1);
      cyc++;
      if (cyc > 300) begin
        chk(16'h0000, 16'h0001);
        print_verdict;
      end
    end
  endtask
  task automatic host_acc(input logic wr, input logic [3:0] sel, input logic [7:0] d);
    @(posedge i_mclk);
    {i_tx_chip_select_n, i_write_n, i_rx_sample_chip_select_n, i_read_n} <= {~wr, ~wr, wr, wr};
    i_reg_select <= sel;
    i_data <= d;
    i_core_rd_data <= ~d;
    @(posedge i_mclk);
    {i_tx_chip_select_n, i_write_n, i_rx_sample_chip_select_n, i_read_n} <= 4'hF;
    tick(1);
  endtask
  initial begin
    tick(2);
    chk({o_card_power_clear_n, o_cfg}, 16'h07C1);
    repeat (18) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    wait_for(0, n);
    chk(16'(n >= 19 && n <= 21), 16'h0001);
    chk({o_card_power_clear_n, o_cfg}, 16'h0FC1);
    host_acc(1'b1, 4'h3, 8'hA5);
    chk({15'h0000, o_core_wr}, 16'h0000);
    wait_for(1, n);
    chk(16'(n + 2 >= 9 && n + 2 <= 11), 16'h0001);
    host_acc(1'b1, 4'h3, 8'hA5);
    chk({o_core_wr, o_core_sel, o_core_wr_data}, 16'h13A5);
    host_acc(1'b0, 4'h5, 8'hA5);
    chk({o_bus.data_oe, o_bus.data_out}, 16'h015A);
    @(posedge i_mclk);
    {i_rx_baud_chip_select_n, i_read_n, i_core_rd_data} <= {2'b00, 8'h3C};
    @(posedge i_mclk);
    {i_rx_baud_chip_select_n, i_read_n} <= 2'b11;
    tick(1);
    chk({o_bus.data_oe, o_bus.data_out}, 16'h013C);
    @(posedge i_mclk);
    {i_core_rx_data, i_core_carrier, i_ext_tx_clock, i_core_irq, i_core_rx_clock} <= 5'h1F;
    tick(3);
    chk({o_serial.rx_data_clock, o_serial.rx_data, o_serial.line_signal_detect,
         o_serial.tx_data_clock}, 16'h000E);
    chk({15'h0000, o_bus.irq_oe}, 16'h0000);
    @(posedge i_mclk);
    i_card_write_n <= 1'b0;
    @(posedge i_mclk);
    i_card_write_n <= 1'b1;
    tick(4);
    chk({o_cfg.ext_tx_clk_sel, o_cfg.short_echo_tone, o_serial.tx_data_clock}, 16'h0007);
    go <= 1'b1;
    tick(5);
    chk({o_serial.clear_to_send, o_core_tx_data}, 16'h0002);
    go <= 1'b0;
    tick(4);
    chk({o_serial.clear_to_send, o_core_tx_data}, 16'h0001);
    @(posedge i_mclk);
    i_ext_reset_n <= 1'b0;
    repeat (30) @(posedge i_mclk);
    i_ext_reset_n <= 1'b1;
    tick(2);
    chk({o_card_power_clear_n, o_cfg}, 16'h07C1);
    wait_for(0, n);
    chk(16'(n >= 1 && n <= 3), 16'h0001);
    wait_for(1, n);
    chk(16'(n >= 9 && n <= 11), 16'h0001);
    @(posedge i_mclk);
    i_supply_low <= 1'b1;
    repeat (5) @(posedge i_mclk);
    i_supply_low <= 1'b0;
    tick(2);
    chk({15'h0000, o_card_power_clear_n}, 16'h0001);
    @(posedge i_mclk);
    i_supply_low <= 1'b1;
    repeat (11) @(posedge i_mclk);
    i_supply_low <= 1'b0;
    tick(1);
    chk({15'h0000, o_card_power_clear_n}, 16'h0000);
    print_verdict;
  end
endmodule
`default_nettype wire
